/* verilog/brf_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "brf_cfg.svh"
module brf_top (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // operand read port
  input  wire logic        rd_req_i,
  input  wire logic [3:0]  rd_idx_i,
  input  wire logic [1:0]  rd_size_i,
  input  wire logic        rd_hi_i,
  input  wire logic [3:0]  rd_bit_i,
  output logic      [31:0] rd_data_o,
  output logic             rd_valid_o,
  output logic             rd_err_o,
  // operand write port
  input  wire logic        wr_req_i,
  input  wire logic [3:0]  wr_idx_i,
  input  wire logic [1:0]  wr_size_i,
  input  wire logic        wr_hi_i,
  input  wire logic [3:0]  wr_bit_i,
  input  wire logic [31:0] wr_data_i,
  output logic             wr_err_o,
  // status word from execution logic
  input  wire logic        psw_wr_i,
  input  wire logic [2:0]  psw_wdata_i,
  output logic      [2:0]  psw_o,
  // interrupt entry
  input  wire logic        irq_entry_i,
  input  wire logic [1:0]  irq_bank_i,
  output logic      [15:0] push_addr_o,
  output logic             push_valid_o,
  output logic             busy_o,
  // memory address generation
  input  wire logic        mem_req_i,
  input  wire logic        mem_word_i,
  input  wire logic [23:0] mem_addr_i,
  output logic      [23:0] mem_addr_o,
  output logic      [1:0]  mem_be_o,
  output logic             mem_valid_o
);
  logic [1:0]            bank;
  logic                  sm;
  logic                  cfg_small;
  logic                  cfg_global;
  logic                  err_sticky;
  brf_pkg::brf_state_t   state;
  brf_pkg::brf_state_t   next_state;
  logic                  idle;
  logic                  rd_ok;
  logic                  rd_bad;
  logic                  wr_ok;
  logic                  wr_bad;
  logic                  s1_valid;
  logic                  s1_err;
  brf_pkg::brf_size_t    s1_size;
  logic                  s1_hi;
  logic [3:0]            s1_bit;
  logic                  we_a;
  logic [4:0]            wa_a;
  logic [15:0]           mask_a;
  logic [15:0]           wd_a;
  logic                  we_b;
  logic [4:0]            wa_b;
  logic [15:0]           mask_b;
  logic [15:0]           wd_b;
  logic [4:0]            ra_a;
  logic [4:0]            ra_b;
  logic [15:0]           q_a;
  logic [15:0]           q_b;
  logic [15:0]           new_ssp;
  logic                  apb_acc;
  logic                  apb_wr;
  logic                  apb_hit;
  logic [31:0]           apb_rdata;

  // map architectural index to storage slot using the live bank and mode
  function automatic logic [4:0] slot(input logic [3:0] idx,
                                      input logic [1:0] bk,
                                      input logic       mode);
    logic [4:0] s;
    s = {2'b11, idx[2:0]};                                 // globals 8-15
    if (idx[3:2] == 2'b00)
      s = {1'b0, bk, idx[1:0]};
    else if (idx == 4'h7)
      s = mode ? `BRF_SLOT_SSP : `BRF_SLOT_USP;
    else if (idx[3] == 1'b0)
      s = {3'b100, idx[1:0]};
    return s;
  endfunction

  // legality: globals only when enabled, no bytes on them, doubles on even index
  function automatic logic legal(input logic [3:0] idx,
                                 input logic [1:0] sz);
    logic ok;
    ok = 1'b1;
    if (idx[3] && !cfg_global)
      ok = 1'b0;
    if (idx[3] && sz == brf_pkg::SZ_BYTE)
      ok = 1'b0;
    if (idx[0] && sz == brf_pkg::SZ_DWORD)
      ok = 1'b0;
    return ok;
  endfunction

  // cpu ports are refused while the push sequencer owns port b
  assign idle   = (state == brf_pkg::ST_IDLE);
  assign rd_ok  = rd_req_i && idle && legal(rd_idx_i, rd_size_i);
  assign rd_bad = rd_req_i && idle && !legal(rd_idx_i, rd_size_i);
  assign wr_ok  = wr_req_i && idle && legal(wr_idx_i, wr_size_i);
  assign wr_bad = wr_req_i && idle && !legal(wr_idx_i, wr_size_i);

  // read addresses follow the status bits of this cycle, never a stale copy
  assign ra_a = slot(rd_idx_i, bank, sm);
  assign ra_b = (state == brf_pkg::ST_PUSH_RD) ? `BRF_SLOT_SSP
                : slot(rd_idx_i | 4'h1, bank, sm);

  // pushes always decrement the system pointer, downward by one word
  assign new_ssp = q_b - `BRF_SP_STEP;

  // write port a: byte, word, low half of doubleword, bit
  always_comb
  begin
    we_a   = wr_ok;
    wa_a   = slot(wr_idx_i, bank, sm);
    mask_a = 16'hFFFF;
    wd_a   = wr_data_i[15:0];
    case (brf_pkg::brf_size_t'(wr_size_i))
      brf_pkg::SZ_BYTE:
      begin
        mask_a = wr_hi_i ? 16'hFF00 : 16'h00FF;
        wd_a   = {wr_data_i[7:0], wr_data_i[7:0]};
      end
      brf_pkg::SZ_BIT:
      begin
        mask_a = 16'h0001 << wr_bit_i;
        wd_a   = {16{wr_data_i[0]}};
      end
      default:
      begin
        mask_a = 16'hFFFF;
        wd_a   = wr_data_i[15:0];
      end
    endcase
  end

  // write port b: high word of a doubleword, or the system pointer update
  always_comb
  begin
    we_b   = 1'b0;
    wa_b   = slot(wr_idx_i | 4'h1, bank, sm);
    mask_b = 16'hFFFF;
    wd_b   = wr_data_i[31:16];
    if (state == brf_pkg::ST_PUSH_WR)
    begin
      we_b = 1'b1;
      wa_b = `BRF_SLOT_SSP;
      wd_b = new_ssp;
    end
    else if (wr_ok && wr_size_i == brf_pkg::SZ_DWORD)
      we_b = 1'b1;
  end

  // storage of all banks, pointers and globals
  brf_mem u_mem (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .we_a_i    (we_a),
    .wa_a_i    (wa_a),
    .mask_a_i  (mask_a),
    .wd_a_i    (wd_a),
    .we_b_i    (we_b),
    .wa_b_i    (wa_b),
    .mask_b_i  (mask_b),
    .wd_b_i    (wd_b),
    .ra_a_i    (ra_a),
    .ra_b_i    (ra_b),
    .q_a_o     (q_a),
    .q_b_o     (q_b)
  );

  // read stage one: remember how to format the storage output
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      s1_valid <= 1'b0;
      s1_err   <= 1'b0;
      s1_size  <= brf_pkg::SZ_WORD;
      s1_hi    <= 1'b0;
      s1_bit   <= 4'h0;
    end
    else
    begin
      s1_valid <= rd_ok;
      s1_err   <= rd_bad;
      s1_size  <= brf_pkg::brf_size_t'(rd_size_i);
      s1_hi    <= rd_hi_i;
      s1_bit   <= rd_bit_i;
    end
  end

  // read stage two: registered operand, two cycles after the request
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      rd_data_o  <= 32'h0000_0000;
      rd_valid_o <= 1'b0;
      rd_err_o   <= 1'b0;
    end
    else
    begin
      rd_valid_o <= s1_valid;
      rd_err_o   <= s1_err;
      if (s1_valid)
      begin
        case (s1_size)
          brf_pkg::SZ_BYTE:
            rd_data_o <= {24'h00_0000, s1_hi ? q_a[15:8] : q_a[7:0]};
          brf_pkg::SZ_DWORD:
            rd_data_o <= {q_b, q_a};
          brf_pkg::SZ_BIT:
            rd_data_o <= {31'h0000_0000, q_a[s1_bit]};
          default:
            rd_data_o <= {16'h0000, q_a};
        endcase
      end
    end
  end

  // rejected writes are flagged for one cycle and change nothing but the sticky error
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      wr_err_o <= 1'b0;
    else
      wr_err_o <= wr_bad;
  end

  // push sequencer: read the system pointer, then write it back lowered
  always_comb
  begin
    case (state)
      brf_pkg::ST_IDLE:
        next_state = irq_entry_i ? brf_pkg::ST_PUSH_RD : brf_pkg::ST_IDLE;
      brf_pkg::ST_PUSH_RD:
        next_state = brf_pkg::ST_PUSH_WR;
      brf_pkg::ST_PUSH_WR:
        next_state = brf_pkg::ST_IDLE;
      default:
        next_state = brf_pkg::ST_IDLE;
    endcase
  end

  // state and the busy flag that mirrors it
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      state  <= brf_pkg::ST_IDLE;
      busy_o <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      busy_o <= (next_state != brf_pkg::ST_IDLE);
    end
  end

  // push address goes out with the pointer update, segment zero
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      push_addr_o  <= 16'h0000;
      push_valid_o <= 1'b0;
    end
    else
    begin
      push_valid_o <= (state == brf_pkg::ST_PUSH_WR);
      if (state == brf_pkg::ST_PUSH_WR)
        push_addr_o <= new_ssp;
    end
  end

  // apb: pready rises in the second access cycle, transfer completes there
  assign apb_acc = psel_i && penable_i && pready_o;
  assign apb_wr  = apb_acc && pwrite_i;
  assign apb_hit = (paddr_i == `BRF_PSW_OFS) || (paddr_i == `BRF_CFG_OFS)
                   || (paddr_i == `BRF_STAT_OFS);

  // status bits: interrupt entry beats the cpu, which beats software
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      {sm, bank} <= `BRF_PSW_RST;                          // user mode, bank 0
    end
    else if (irq_entry_i)
    begin
      bank <= irq_bank_i;
      sm   <= 1'b1;
    end
    else if (psw_wr_i)
    begin
      bank <= psw_wdata_i[`BRF_PSW_BANK_HI:`BRF_PSW_BANK_LO];
      sm   <= psw_wdata_i[`BRF_PSW_SM];
    end
    else if (apb_wr && paddr_i == `BRF_PSW_OFS)
    begin
      bank <= pwdata_i[`BRF_PSW_BANK_HI:`BRF_PSW_BANK_LO];
      sm   <= pwdata_i[`BRF_PSW_SM];
    end
  end

  // configuration: small-memory mode and presence of the globals
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      {cfg_global, cfg_small} <= `BRF_CFG_RST;             // baseline core, full addresses
    end
    else if (apb_wr && paddr_i == `BRF_CFG_OFS)
    begin
      cfg_small  <= pwdata_i[`BRF_CFG_SMALL];
      cfg_global <= pwdata_i[`BRF_CFG_GLOBAL];
    end
  end

  // sticky access error; a new error in the clearing cycle wins
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      err_sticky <= 1'b0;
    else if (rd_bad || wr_bad)
      err_sticky <= 1'b1;
    else if (apb_wr && paddr_i == `BRF_STAT_OFS && pwdata_i[`BRF_STAT_ERR])
      err_sticky <= 1'b0;
  end

  // apb read mux; unused bits read zero
  always_comb
  begin
    apb_rdata = 32'h0000_0000;
    case (paddr_i)
      `BRF_PSW_OFS:
      begin
        apb_rdata[`BRF_PSW_BANK_HI:`BRF_PSW_BANK_LO] = bank;
        apb_rdata[`BRF_PSW_SM] = sm;
      end
      `BRF_CFG_OFS:
      begin
        apb_rdata[`BRF_CFG_SMALL]  = cfg_small;
        apb_rdata[`BRF_CFG_GLOBAL] = cfg_global;
      end
      `BRF_STAT_OFS:
      begin
        apb_rdata[`BRF_STAT_BANK_HI:`BRF_STAT_BANK_LO] = bank;
        apb_rdata[`BRF_STAT_SM]   = sm;
        apb_rdata[`BRF_STAT_BUSY] = busy_o;
        apb_rdata[`BRF_STAT_ERR]  = err_sticky;
      end
      default:
        apb_rdata = 32'h0000_0000;
    endcase
  end

  // apb handshake and registered answer
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end
    else
    begin
      pready_o  <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !apb_hit;
      if (psel_i && penable_i && !pready_o && !pwrite_i)
        prdata_o <= apb_rdata;
    end
  end

  // status word mirror for the execution logic
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      psw_o <= `BRF_PSW_RST;
    else
      psw_o <= {sm, bank};
  end

  // memory address unit; registers never appear here, their space is apart
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      mem_addr_o  <= 24'h00_0000;
      mem_be_o    <= 2'b00;
      mem_valid_o <= 1'b0;
    end
    else
    begin
      mem_valid_o <= mem_req_i;
      if (mem_req_i)
      begin
        mem_addr_o[23:16] <= cfg_small ? 8'h00 : mem_addr_i[23:16];
        mem_addr_o[15:1]  <= mem_addr_i[15:1];
        mem_addr_o[0]     <= mem_word_i ? 1'b0 : mem_addr_i[0];
        if (mem_word_i)
          mem_be_o <= 2'b11;
        else
          mem_be_o <= mem_addr_i[0] ? 2'b10 : 2'b01;
      end
    end
  end
endmodule
`default_nettype wire

/* verilog/brf_cfg.svh */
`ifndef BRF_CFG_SVH
`define BRF_CFG_SVH
// apb register byte offsets
`define BRF_PSW_OFS 12'h000
`define BRF_CFG_OFS 12'h004
`define BRF_STAT_OFS 12'h008
// program_status_word fields
`define BRF_PSW_BANK_LO 0
`define BRF_PSW_BANK_HI 1
`define BRF_PSW_SM 2
`define BRF_PSW_RST 3'h0
// configuration fields
`define BRF_CFG_SMALL 0
`define BRF_CFG_GLOBAL 1
`define BRF_CFG_RST 2'h0
// status fields
`define BRF_STAT_BANK_LO 0
`define BRF_STAT_BANK_HI 1
`define BRF_STAT_SM 2
`define BRF_STAT_BUSY 3
`define BRF_STAT_ERR 4
// physical slots of the storage array
`define BRF_SLOT_USP 5'h13
`define BRF_SLOT_SSP 5'h14
`define BRF_DEPTH 32
// stack moves one word per push, downward
`define BRF_SP_STEP 16'h0002
`endif

/* verilog/brf_pkg.sv */
package brf_pkg;
  // operand width of a register access
  typedef enum logic [1:0] {
    SZ_BYTE  = 2'b00,
    SZ_WORD  = 2'b01,
    SZ_DWORD = 2'b10,
    SZ_BIT   = 2'b11
  } brf_size_t;
  // interrupt stack push sequencer
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_PUSH_RD = 2'b01,
    ST_PUSH_WR = 2'b10
  } brf_state_t;
endpackage

/* verilog/brf_mem.sv */
`timescale 1ns/1ps
`default_nettype none
`include "brf_cfg.svh"
module brf_mem (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  // write port a
  input  wire logic        we_a_i,
  input  wire logic [4:0]  wa_a_i,
  input  wire logic [15:0] mask_a_i,
  input  wire logic [15:0] wd_a_i,
  // write port b, applied after port a
  input  wire logic        we_b_i,
  input  wire logic [4:0]  wa_b_i,
  input  wire logic [15:0] mask_b_i,
  input  wire logic [15:0] wd_b_i,
  // registered read ports
  input  wire logic [4:0]  ra_a_i,
  input  wire logic [4:0]  ra_b_i,
  output logic      [15:0] q_a_o,
  output logic      [15:0] q_b_o
);
  logic [15:0] mem [`BRF_DEPTH];
  // one word per slot; bit masks give byte and bit writes
  genvar g;
  for (g = 0; g < `BRF_DEPTH; g++)
  begin : g_slot
    logic [15:0] after_a;
    assign after_a = (we_a_i && wa_a_i == 5'(g)) ?
                     ((mem[g] & ~mask_a_i) | (wd_a_i & mask_a_i)) : mem[g];
    always_ff @(posedge ref_clk_i)
    begin
      if (!nrst_i)
        mem[g] <= 16'h0000;
      else if (we_b_i && wa_b_i == 5'(g))
        mem[g] <= (after_a & ~mask_b_i) | (wd_b_i & mask_b_i);
      else
        mem[g] <= after_a;
    end
  end
  // reads see the value before this edge's writes
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      q_a_o <= 16'h0000;
      q_b_o <= 16'h0000;
    end
    else
    begin
      q_a_o <= mem[ra_a_i];
      q_b_o <= mem[ra_b_i];
    end
  end
endmodule
`default_nettype wire

/* testbench/brf_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module brf_top_props (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  // apb handshake
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pready_o,
  // operand read port
  input  wire logic        rd_req_i,
  input  wire logic [3:0]  rd_idx_i,
  input  wire logic [1:0]  rd_size_i,
  input  wire logic        rd_valid_o,
  input  wire logic        rd_err_o,
  // status and interrupt
  input  wire logic        psw_wr_i,
  input  wire logic [2:0]  psw_wdata_i,
  input  wire logic [2:0]  psw_o,
  input  wire logic        irq_entry_i,
  input  wire logic [1:0]  irq_bank_i,
  input  wire logic        push_valid_o,
  input  wire logic        busy_o,
  // memory address
  input  wire logic        mem_req_i,
  input  wire logic        mem_word_i,
  input  wire logic [23:0] mem_addr_i,
  input  wire logic [23:0] mem_addr_o,
  input  wire logic [1:0]  mem_be_o,
  input  wire logic        mem_valid_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  logic [2:0] want_psw;
  // last status value asked for; interrupt entry wins over a plain write
  always_ff @(posedge ref_clk_i)
  begin
    if (irq_entry_i)
      want_psw <= {1'b1, irq_bank_i};
    else if (psw_wr_i)
      want_psw <= psw_wdata_i;
  end
  // push sequencer: two busy cycles, then one push pulse
  sequence s_busy2;
    busy_o [*2];
  endsequence
  sequence s_push;
    push_valid_o && !busy_o;
  endsequence
  chk_push_order: assert property (irq_entry_i && !busy_o |=> s_busy2 ##1 s_push)
    else $error("push sequence out of order");
  chk_psw_follow: assert property ((irq_entry_i || psw_wr_i) ##1 !(irq_entry_i || psw_wr_i)
    |-> ##1 psw_o == want_psw)
    else $error("status mirror did not follow");
  chk_global_byte: assert property (rd_req_i && !busy_o && rd_idx_i[3]
    && rd_size_i == brf_pkg::SZ_BYTE |-> ##2 rd_err_o && !rd_valid_o)
    else $error("byte read of global register accepted");
  chk_dword_odd: assert property (rd_req_i && !busy_o && rd_idx_i[0]
    && rd_size_i == brf_pkg::SZ_DWORD |-> ##2 rd_err_o && !rd_valid_o)
    else $error("odd doubleword read accepted");
  chk_base_read: assert property (rd_req_i && !busy_o && !rd_idx_i[3]
    && rd_size_i == brf_pkg::SZ_WORD |-> ##2 rd_valid_o && !rd_err_o)
    else $error("baseline word read not answered");
  chk_word_even: assert property (mem_req_i && mem_word_i |=> mem_valid_o
    && mem_be_o == 2'h3 && !mem_addr_o[0])
    else $error("word access not aligned");
  chk_byte_lane: assert property (mem_req_i && !mem_word_i |=> mem_valid_o
    && mem_be_o == ($past(mem_addr_i[0]) ? 2'h2 : 2'h1))
    else $error("byte lane wrong");
  chk_addr_pass: assert property (mem_req_i |=> mem_addr_o[15:1] == $past(mem_addr_i[15:1]))
    else $error("address bits lost");
  chk_apb_wait: assert property (psel_i && !penable_i |=> ##1 pready_o)
    else $error("apb answer late");
endmodule
bind brf_top brf_top_props brf_top_props_inst (.*);
`default_nettype wire

/* testbench/brf_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module brf_cpu_model (
  // clock
  input  wire logic        ref_clk_i,
  // operand ports
  output logic             rd_req_i,
  output logic      [3:0]  rd_idx_i,
  output logic      [1:0]  rd_size_i,
  output logic             rd_hi_i,
  output logic      [3:0]  rd_bit_i,
  input  wire logic [31:0] rd_data_o,
  input  wire logic        rd_valid_o,
  input  wire logic        rd_err_o,
  output logic             wr_req_i,
  output logic      [3:0]  wr_idx_i,
  output logic      [1:0]  wr_size_i,
  output logic             wr_hi_i,
  output logic      [3:0]  wr_bit_i,
  output logic      [31:0] wr_data_i,
  input  wire logic        wr_err_o,
  // status and interrupt
  output logic             psw_wr_i,
  output logic      [2:0]  psw_wdata_i,
  output logic             irq_entry_i,
  output logic      [1:0]  irq_bank_i,
  input  wire logic [15:0] push_addr_o,
  input  wire logic        push_valid_o,
  // memory address
  output logic             mem_req_i,
  output logic             mem_word_i,
  output logic      [23:0] mem_addr_i,
  input  wire logic [23:0] mem_addr_o,
  input  wire logic [1:0]  mem_be_o,
  input  wire logic        mem_valid_o
);
  // everything idle before reset ends
  initial {rd_req_i, rd_idx_i, rd_size_i, rd_hi_i, rd_bit_i, wr_req_i, wr_idx_i, wr_size_i,
    wr_hi_i, wr_bit_i, wr_data_i, psw_wr_i, psw_wdata_i, irq_entry_i, irq_bank_i,
    mem_req_i, mem_word_i, mem_addr_i} = '0;
  // one operand access; a write answers one edge on, a read two
  task automatic access(input logic we, input logic [3:0] idx, input logic [1:0] sz,
    input logic hi, input logic [3:0] bn, input logic [31:0] d,
    output logic [31:0] q, output logic err, output logic ok);
    int n;
    @(posedge ref_clk_i);
    rd_req_i <= !we;
    wr_req_i <= we;
    {rd_idx_i, rd_size_i, rd_hi_i, rd_bit_i} <= {idx, sz, hi, bn};
    {wr_idx_i, wr_size_i, wr_hi_i, wr_bit_i} <= {idx, sz, hi, bn};
    wr_data_i <= d;
    @(posedge ref_clk_i);
    {rd_req_i, wr_req_i} <= 2'h0;
    {q, err, ok} = '0;
    for (n = 0; n < 4 && !ok; n++)
    begin
      @(posedge ref_clk_i);
      ok  = we | rd_valid_o | rd_err_o;
      err = we ? wr_err_o : rd_err_o;
      q   = rd_data_o;
    end
  endtask
  // status write, taken at the next edge
  task automatic set_status(input logic [2:0] v);
    @(posedge ref_clk_i);
    psw_wr_i    <= 1'b1;
    psw_wdata_i <= v;
    @(posedge ref_clk_i);
    psw_wr_i    <= 1'b0;
  endtask
  // interrupt entry, bounded wait for the push pulse
  task automatic interrupt(input logic [1:0] bank, output logic [15:0] sp, output logic ok);
    int n;
    @(posedge ref_clk_i);
    irq_entry_i <= 1'b1;
    irq_bank_i  <= bank;
    @(posedge ref_clk_i);
    irq_entry_i <= 1'b0;
    {sp, ok} = '0;
    for (n = 0; n < 6 && !ok; n++)
    begin
      @(posedge ref_clk_i);
      ok = push_valid_o;
      sp = push_addr_o;
    end
  endtask
  // address generation answers one edge after the request
  task automatic mem_access(input logic word, input logic [23:0] a,
    output logic [23:0] ao, output logic [1:0] be, output logic ok);
    @(posedge ref_clk_i);
    mem_req_i  <= 1'b1;
    mem_word_i <= word;
    mem_addr_i <= a;
    @(posedge ref_clk_i);
    mem_req_i  <= 1'b0;
    @(posedge ref_clk_i);
    ok = mem_valid_o;
    ao = mem_addr_o;
    be = mem_be_o;
  endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "brf_cfg.svh"
module tb_top;
  localparam logic [1:0] SZB = brf_pkg::SZ_BYTE;
  localparam logic [1:0] SZW = brf_pkg::SZ_WORD;
  localparam logic [1:0] SZD = brf_pkg::SZ_DWORD;
  localparam logic [1:0] SZT = brf_pkg::SZ_BIT;
  // clock, reset and apb master
  logic             ref_clk_i;
  logic             nrst_i;
  logic             psel_i, penable_i, pwrite_i;
  logic      [11:0] paddr_i;
  logic      [31:0] pwdata_i;
  // nets between design and cpu model
  wire logic        pready_o, pslverr_o, rd_req_i, rd_hi_i, rd_valid_o, rd_err_o, wr_req_i;
  wire logic        wr_hi_i, wr_err_o, psw_wr_i, irq_entry_i, push_valid_o, busy_o;
  wire logic        mem_req_i, mem_word_i, mem_valid_o;
  wire logic [1:0]  rd_size_i, wr_size_i, irq_bank_i, mem_be_o;
  wire logic [2:0]  psw_wdata_i, psw_o;
  wire logic [3:0]  rd_idx_i, rd_bit_i, wr_idx_i, wr_bit_i;
  wire logic [15:0] push_addr_o;
  wire logic [23:0] mem_addr_i, mem_addr_o;
  wire logic [31:0] prdata_o, rd_data_o, wr_data_i;
  // bench state
  int               failures, checked, i;
  logic      [31:0] q;
  logic             err, ok;
  logic      [15:0] sp;
  brf_top       brf_top_inst (.*);
  brf_cpu_model brf_cpu_model_inst (.*);
  // free-running core clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // a missing answer is counted and ends the run
  task automatic need(input logic got);
    if (got !== 1'b1)
    begin
      failures++;
      $display("[ERR] %0t no answer", $time);
      stop_test;
    end
  endtask
  // apb transfer held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    for (n = 0; n < 8 && pready_o !== 1'b1; n++)
      @(posedge ref_clk_i);
    need(pready_o);
    q   = prdata_o;
    err = pslverr_o;
    {psel_i, penable_i} <= 2'h0;
  endtask
  task automatic wr(input logic [3:0] x, input logic [1:0] sz, input logic hi,
    input logic [3:0] bn, input logic [31:0] d, input logic e);
    brf_cpu_model_inst.access(1'b1, x, sz, hi, bn, d, q, err, ok);
    need(ok);
    check({31'h0, err}, {31'h0, e});
  endtask
  // read compared only over the width of its size
  task automatic rd(input logic [3:0] x, input logic [1:0] sz, input logic hi,
    input logic [3:0] bn, input logic [31:0] exp, input logic e);
    logic [31:0] m;
    m = sz == SZB ? 32'hFF : sz == SZW ? 32'hFFFF : sz == SZT ? 32'h1 : 32'hFFFF_FFFF;
    brf_cpu_model_inst.access(1'b0, x, sz, hi, bn, 32'h0, q, err, ok);
    need(ok);
    check({31'h0, err}, {31'h0, e});
    check(e ? 32'h0 : q & m, e ? 32'h0 : exp);
  endtask
  task automatic mem(input logic w, input logic [23:0] a, input logic [23:0] ea,
    input logic [1:0] eb);
    logic [23:0] ao;
    logic [1:0]  be;
    brf_cpu_model_inst.mem_access(w, a, ao, be, ok);
    need(ok);
    check({6'h0, be, ao}, {6'h0, eb, ea});
  endtask
  // main sequence
  initial
  begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {failures, checked} = '0;
    nrst_i = 1'b0;
    repeat (8) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    apb(1'b0, `BRF_PSW_OFS, 32'h0);
    check(q, 32'h0);
    apb(1'b0, `BRF_CFG_OFS, 32'h0);
    check(q, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    check({31'h0, err}, 32'h1);
    rd(4'h8, SZW, 1'b0, 4'h0, 32'h0, 1'b1);
    // refused access leaves the sticky error set until software clears it
    apb(1'b0, `BRF_STAT_OFS, 32'h0);
    check(q & 32'h10, 32'h10);
    apb(1'b1, `BRF_STAT_OFS, 32'h10);
    apb(1'b0, `BRF_STAT_OFS, 32'h0);
    check(q & 32'h10, 32'h0);
    // globals present: word and bit accepted, byte refused
    apb(1'b1, `BRF_CFG_OFS, 32'h2);
    wr(4'h9, SZW, 1'b0, 4'h0, 32'h9A5C, 1'b0);
    wr(4'h9, SZT, 1'b0, 4'hF, 32'h0, 1'b0);
    rd(4'h9, SZW, 1'b0, 4'h0, 32'h1A5C, 1'b0);
    rd(4'h9, SZB, 1'b0, 4'h0, 32'h0, 1'b1);
    wr(4'hA, SZB, 1'b1, 4'h0, 32'h11, 1'b1);
    for (i = 0; i < 7; i++)
      wr(i[3:0], SZW, 1'b0, 4'h0, 32'h0A00 + i, 1'b0);
    for (i = 0; i < 7; i++)
      rd(i[3:0], SZW, 1'b0, 4'h0, 32'h0A00 + i, 1'b0);
    wr(4'h1, SZB, 1'b1, 4'h0, 32'hAB, 1'b0);
    wr(4'h1, SZB, 1'b0, 4'h0, 32'hCD, 1'b0);
    rd(4'h1, SZW, 1'b0, 4'h0, 32'hABCD, 1'b0);
    rd(4'h1, SZB, 1'b1, 4'h0, 32'hAB, 1'b0);
    rd(4'h1, SZB, 1'b0, 4'h0, 32'hCD, 1'b0);
    wr(4'h4, SZD, 1'b0, 4'h0, 32'h1234_5678, 1'b0);
    rd(4'h5, SZW, 1'b0, 4'h0, 32'h1234, 1'b0);
    rd(4'h4, SZD, 1'b0, 4'h0, 32'h1234_5678, 1'b0);
    rd(4'h5, SZD, 1'b0, 4'h0, 32'h0, 1'b1);
    wr(4'h3, SZD, 1'b0, 4'h0, 32'h0, 1'b1);
    // one copy of register 2 per bank, read back from system mode
    for (i = 0; i < 4; i++)
    begin
      brf_cpu_model_inst.set_status({1'b0, i[1:0]});
      wr(4'h2, SZW, 1'b0, 4'h0, 32'h0B00 + i, 1'b0);
    end
    apb(1'b0, `BRF_STAT_OFS, 32'h0);
    check(q & 32'h7, 32'h3);
    for (i = 0; i < 4; i++)
    begin
      brf_cpu_model_inst.set_status({1'b1, i[1:0]});
      rd(4'h2, SZW, 1'b0, 4'h0, 32'h0B00 + i, 1'b0);
    end
    brf_cpu_model_inst.set_status(3'h0);
    wr(4'h7, SZW, 1'b0, 4'h0, 32'h0100, 1'b0);
    brf_cpu_model_inst.set_status(3'h4);
    wr(4'h7, SZW, 1'b0, 4'h0, 32'h0200, 1'b0);
    wr(4'h7, SZT, 1'b0, 4'h4, 32'h1, 1'b0);
    brf_cpu_model_inst.set_status(3'h0);
    rd(4'h7, SZW, 1'b0, 4'h0, 32'h0100, 1'b0);
    brf_cpu_model_inst.set_status(3'h1);
    wr(4'h0, SZT, 1'b0, 4'h3, 32'h1, 1'b0);
    rd(4'h0, SZW, 1'b0, 4'h0, 32'h0008, 1'b0);
    rd(4'h0, SZT, 1'b0, 4'h3, 32'h1, 1'b0);
    brf_cpu_model_inst.set_status(3'h0);
    rd(4'h0, SZW, 1'b0, 4'h0, 32'h0A00, 1'b0);
    // interrupt from user mode pushes on the system stack
    brf_cpu_model_inst.interrupt(2'h2, sp, ok);
    need(ok);
    check({16'h0, sp}, 32'h020E);
    rd(4'h7, SZW, 1'b0, 4'h0, 32'h020E, 1'b0);
    rd(4'h2, SZW, 1'b0, 4'h0, 32'h0B02, 1'b0);
    apb(1'b0, `BRF_STAT_OFS, 32'h0);
    check(q & 32'h7, 32'h6);
    brf_cpu_model_inst.set_status(3'h0);
    rd(4'h7, SZW, 1'b0, 4'h0, 32'h0100, 1'b0);
    // address generation, full then small memory
    mem(1'b1, 24'h12_3457, 24'h12_3456, 2'h3);
    mem(1'b0, 24'h12_3457, 24'h12_3457, 2'h2);
    mem(1'b0, 24'h12_3456, 24'h12_3456, 2'h1);
    mem(1'b1, 24'h12_3456, 24'h12_3456, 2'h3);
    apb(1'b1, `BRF_CFG_OFS, 32'h3);
    mem(1'b1, 24'hAB_1235, 24'h00_1234, 2'h3);
    stop_test;
  end
endmodule
`default_nettype wire
